// ---- hw/fpic_ctrl.sv ----
// Fixed-priority interrupt controller top: request capture, level-7 edge
// latches, winner presentation to the core, acknowledge read, wake-up.
// Assumes peripheral requests come from logic on ref_clk; the core pulses
// core_ack for one cycle when it takes the presented request.
//
// Overview of operation
// - Controller window is 64 bytes at 0xFF_FFC0 to 0xFF_FFFF.
// - Winning level and vector go to the core on dedicated signals.
// - Thirty peripheral requests plus seven software requests, one per level.
// - Each peripheral has fixed level and position; seven levels, five positions.
// - Two sources can be remapped to the top slots of level 6.
// - Vector equals 64 plus source index, indices 0 to 36.
// - Vector also equals the legacy vector number plus 62.
// - Acknowledge read from a service routine returns the top pending vector.
// - Combinational wake-up output raised by any pending request, no clock needed.
// - Level 7 is edge-sensitive and non-maskable; others level-sensitive, held.
`timescale 1ns/1ns
`include "fpic_params.svh"

module fpic_ctrl
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Requests
  input wire logic [`FPIC_NUM_PERIPH-1:0] periph_req,
  input wire logic [`FPIC_NUM_LEVELS:1] sw_req,
  // Remap slots
  input wire logic remap0_en,
  input wire logic [4:0] remap0_src,
  input wire logic remap1_en,
  input wire logic [4:0] remap1_src,
  // Core side
  input wire logic core_ack,
  output logic [2:0] irq_level_q,
  output logic [7:0] irq_vector_q,
  // Acknowledge read
  input wire logic ack_rd,
  input wire logic [23:0] ack_addr,
  output logic ack_valid_q,
  output logic [7:0] ack_data_q,
  // Wake-up
  output logic wake
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_n_q;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Request capture
  // ----------------------------------------------------------------
  logic [`FPIC_NUM_SRC-1:0] raw_req;
  logic [`FPIC_NUM_SRC-1:0] raw_prev_q;
  logic [`FPIC_NUM_SRC-1:0] edge_q;
  logic [`FPIC_NUM_SRC-1:0] edge_d;
  logic [`FPIC_NUM_SRC-1:0] nmi_src;
  logic [`FPIC_NUM_SRC-1:0] pend;
  logic win_valid;
  fpic_pkg::fpic_level_type win_level;
  fpic_pkg::fpic_idx_type win_idx;

  assign raw_req = {sw_req, periph_req};

  // A source is edge-sensitive only while its effective level is 7
  always_comb
  begin
    for (int i = 0; i < `FPIC_NUM_SRC; i++)
    begin
      nmi_src[i] = fpic_pkg::native_level(6'(i)) == `FPIC_NMI_LEVEL
        && !(remap0_en && i == int'(remap0_src))
        && !(remap1_en && i == int'(remap1_src));
    end
  end

  // Level 7 latches its rising edge until the core takes it; a new edge
  // in the same cycle as the take wins, so no event is dropped
  always_comb
  begin
    edge_d = edge_q;
    if (core_ack && win_valid && nmi_src[win_idx])
      edge_d[win_idx] = 1'b0;
    edge_d = edge_d | (raw_req & ~raw_prev_q & nmi_src);
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n_q)
  begin
    if (!rst_sync_n_q)
    begin
      raw_prev_q <= '0;
      edge_q <= '0;
    end
    else
    begin
      raw_prev_q <= raw_req;
      edge_q <= edge_d & nmi_src;
    end
  end

  // Other levels simply follow the held request line
  assign pend = (edge_q & nmi_src) | (raw_req & ~nmi_src);

  // ----------------------------------------------------------------
  // Winner search
  // ----------------------------------------------------------------
  fpic_rank u_rank
  (
    .pend(pend),
    .remap0_en(remap0_en),
    .remap0_src(remap0_src),
    .remap1_en(remap1_en),
    .remap1_src(remap1_src),
    .win_valid(win_valid),
    .win_level(win_level),
    .win_idx(win_idx)
  );

  // ----------------------------------------------------------------
  // Core presentation
  // ----------------------------------------------------------------
  // Level 0 means nothing pending; the core masks, this block does not
  always_ff @(posedge ref_clk or negedge rst_sync_n_q)
  begin
    if (!rst_sync_n_q)
    begin
      irq_level_q <= 3'h0;
      irq_vector_q <= 8'h00;
    end
    else
    begin
      irq_level_q <= win_valid ? win_level : 3'h0;
      irq_vector_q <= win_valid ? fpic_pkg::src_vector(win_idx) : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge read
  // ----------------------------------------------------------------
  logic ack_hit;

  assign ack_hit = ack_rd && ack_addr >= `FPIC_WIN_BASE && ack_addr <= `FPIC_WIN_LAST;

  // Reads outside the window are left to other slaves and get no answer
  always_ff @(posedge ref_clk or negedge rst_sync_n_q)
  begin
    if (!rst_sync_n_q)
    begin
      ack_valid_q <= 1'b0;
      ack_data_q <= 8'h00;
    end
    else
    begin
      ack_valid_q <= ack_hit;
      if (ack_hit)
        ack_data_q <= win_valid ? fpic_pkg::src_vector(win_idx) : `FPIC_SPURIOUS_VEC;
    end
  end

  // ----------------------------------------------------------------
  // Wake-up
  // ----------------------------------------------------------------
  // Deliberately unregistered so it works with the clock stopped
  assign wake = |raw_req | |edge_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] legacy_vec;

  assign legacy_vec = irq_vector_q - `FPIC_LEGACY_OFS;

  sequence ack_request_s;
    ack_hit && win_valid;
  endsequence

  sequence ack_answer_s;
    ##1 ack_valid_q && ack_data_q == $past(fpic_pkg::src_vector(win_idx));
  endsequence

  vector_follows_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n_q)
    win_valid |=> irq_vector_q == `FPIC_VEC_BASE + 8'($past(win_idx)))
    else $error("presented vector is not base plus source index");

  legacy_offset_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n_q)
    irq_level_q != 3'h0 |-> legacy_vec + `FPIC_LEGACY_OFS == irq_vector_q
      && legacy_vec >= 8'h02)
    else $error("vector does not match legacy numbering");

  level_follows_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n_q)
    ##1 irq_level_q == ($past(win_valid) ? $past(win_level) : 3'h0))
    else $error("presented level does not follow winner");

  ack_read_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n_q)
    ack_request_s |-> ack_answer_s)
    else $error("acknowledge read returned wrong vector");

  window_decode_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n_q)
    ack_rd && ack_addr < `FPIC_WIN_BASE |=> !ack_valid_q)
    else $error("read below window answered");

  nmi_held_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n_q)
    edge_q[0] && nmi_src[0] && !(core_ack && win_idx == 6'h00)
      && $stable(nmi_src[0]) |=> edge_q[0])
    else $error("level 7 edge dropped before being taken");

  nmi_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n_q)
    $rose(raw_req[0]) && nmi_src[0] && $stable(nmi_src[0]) |-> ##1 pend[0])
    else $error("level 7 edge not latched");

  remap_top_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n_q)
    remap0_en && pend[remap0_src] && !(|(pend & nmi_src))
      |-> win_idx == 6'(remap0_src) && win_level == `FPIC_REMAP_LEVEL)
    else $error("remapped source did not take top maskable slot");

  wake_any_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n_q)
    win_valid |-> wake)
    else $error("pending request without wake-up");

  level_order_a: assert property (@(posedge ref_clk) disable iff (!rst_sync_n_q)
    pend[`FPIC_NUM_SRC-1] |-> win_level == `FPIC_NMI_LEVEL)
    else $error("level 7 request lost to lower level");

endmodule

// ---- hw/fpic_params.svh ----
// Constants of the fixed-priority interrupt controller: window, vector
// arithmetic, source counts and the level and slot codes.
// Assumes inclusion by bare name from every file that needs them.
`ifndef FPIC_PARAMS_SVH
`define FPIC_PARAMS_SVH

// Slave window at the top of the 24-bit map
`define FPIC_WIN_BASE 24'hff_ffc0
`define FPIC_WIN_LAST 24'hff_ffff

// Vector arithmetic
`define FPIC_VEC_BASE 8'h40
`define FPIC_LEGACY_OFS 8'h3e
`define FPIC_SPURIOUS_VEC 8'h18

// Source counts and index layout
`define FPIC_NUM_PERIPH 30
`define FPIC_NUM_LEVELS 7
`define FPIC_NUM_SRC 37
`define FPIC_NUM_POS 9

// Level and priority codes
`define FPIC_NMI_LEVEL 3'h7
`define FPIC_REMAP_LEVEL 3'h6
`define FPIC_PRI_SW 4'h0
`define FPIC_PRI_REMAP0 4'hb
`define FPIC_PRI_REMAP1 4'ha

`endif

// ---- hw/fpic_pkg.sv ----
// Types and source-table functions of the interrupt controller.
// Assumes fpic_params.svh is on the include path.
`include "fpic_params.svh"

package fpic_pkg;

  typedef logic [2:0] fpic_level_type;
  typedef logic [3:0] fpic_pri_type;
  typedef logic [7:0] fpic_vec_type;
  typedef logic [5:0] fpic_idx_type;

  // ----------------------------------------------------------------
  // Hard-wired table
  // ----------------------------------------------------------------
  // Peripherals 0..29 spread from level 7 down to level 1; the software
  // request of level L is source 29+L.
  function automatic fpic_level_type native_level(input fpic_idx_type idx);
    int i;
    i = int'(idx);
    if (i < `FPIC_NUM_PERIPH)
      native_level = 3'(7 - (i * 7) / 30);
    else
      native_level = 3'(i - `FPIC_NUM_PERIPH + 1);
  endfunction

  // Positions 9 (highest) down to 5 inside a level; software sits at 0
  function automatic fpic_pri_type native_pri(input fpic_idx_type idx);
    int i;
    int k;
    int first;
    i = int'(idx);
    k = (i * 7) / 30;
    first = (k * 30 + 6) / 7;
    if (i < `FPIC_NUM_PERIPH)
      native_pri = 4'(`FPIC_NUM_POS - (i - first));
    else
      native_pri = `FPIC_PRI_SW;
  endfunction

  function automatic fpic_vec_type src_vector(input fpic_idx_type idx);
    src_vector = `FPIC_VEC_BASE + 8'(idx);
  endfunction

endpackage

// ---- hw/fpic_rank.sv ----
// Winner search over all pending sources, with the two remap slots.
// Assumes pending and remap inputs are already on the controller clock.
`timescale 1ns/1ns
`include "fpic_params.svh"

module fpic_rank
(
  // Pending sources and remap slots
  input wire logic [`FPIC_NUM_SRC-1:0] pend,
  input wire logic remap0_en,
  input wire logic [4:0] remap0_src,
  input wire logic remap1_en,
  input wire logic [4:0] remap1_src,
  // Winner
  output logic win_valid,
  output fpic_pkg::fpic_level_type win_level,
  output fpic_pkg::fpic_idx_type win_idx
);

  always_comb
  begin
    fpic_pkg::fpic_level_type lvl;
    fpic_pkg::fpic_pri_type pri;
    fpic_pkg::fpic_pri_type best_pri;
    lvl = 3'h0;
    pri = 4'h0;
    best_pri = 4'h0;
    win_valid = 1'b0;
    win_level = 3'h0;
    win_idx = 6'h00;
    for (int i = 0; i < `FPIC_NUM_SRC; i++)
    begin
      lvl = fpic_pkg::native_level(6'(i));
      pri = fpic_pkg::native_pri(6'(i));
      // Remapped sources take the top maskable slots
      if (remap1_en && i == int'(remap1_src))
      begin
        lvl = `FPIC_REMAP_LEVEL;
        pri = `FPIC_PRI_REMAP1;
      end
      if (remap0_en && i == int'(remap0_src))
      begin
        lvl = `FPIC_REMAP_LEVEL;
        pri = `FPIC_PRI_REMAP0;
      end
      // Higher level wins, then higher position; strict compare keeps ties stable
      if (pend[i] && (!win_valid || {lvl, pri} > {win_level, best_pri}))
      begin
        win_valid = 1'b1;
        win_level = lvl;
        best_pri = pri;
        win_idx = 6'(i);
      end
    end
  end

endmodule

// ---- verif/fpic_core_model.sv ----
// Behavioural processor core beside the interrupt controller: compares
// the presented level with its mask, waits a set number of cycles and
// pulses core_ack once for each request it takes.
// Assumes the controller outputs are registered on ref_clk.
`timescale 1ns/1ns

module fpic_core_model
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Controller outputs
  input wire logic [2:0] irq_level,
  input wire logic [7:0] irq_vector,
  // Core state
  input wire logic [2:0] mask,
  input wire logic [3:0] delay,
  // Answer
  output logic core_ack,
  output logic [7:0] taken_vec
);
  logic [3:0] wait_q;
  logic [2:0] busy_q;
  logic take;

  // Level 7 gets through any mask; the last taken level is not taken again until level 0 shows
  assign take = (irq_level > mask || irq_level == 3'h7) && irq_level != busy_q;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wait_q <= 4'h0;
      busy_q <= 3'h0;
      core_ack <= 1'b0;
      taken_vec <= 8'h00;
    end
    else
    begin
      core_ack <= 1'b0;
      // Busy level stops a second ack while a cleared latch drains
      if (irq_level == 3'h0)
        busy_q <= 3'h0;
      if (take && wait_q == delay)
      begin
        core_ack <= 1'b1;
        // Vector word of the stacked frame, fetched after the status copy
        taken_vec <= irq_vector;
        busy_q <= irq_level;
        wait_q <= 4'h0;
      end
      else if (take)
        wait_q <= wait_q + 4'h1;
      else
        wait_q <= 4'h0;
    end
  end
endmodule

// ---- verif/tb_fpic_ctrl.sv ----
// Self-checking bench of the interrupt controller with a core model.
// Assumes fpic_params.svh on the include path and a 100 MHz ref_clk.
`timescale 1ns/1ns
`include "fpic_params.svh"

module tb_fpic_ctrl;
  logic ref_clk, rstn, core_ack, remap0_en, remap1_en, ack_rd, ack_valid_q, wake, hit;
  logic [29:0] periph_req;
  logic [7:1] sw_req;
  logic [4:0] remap0_src, remap1_src;
  logic [2:0] irq_level_q, mask;
  logic [7:0] irq_vector_q, ack_data_q, taken_vec, v;
  logic [23:0] ack_addr;
  logic [3:0] delay;
  int err_total = 0;
  int cmp_count = 0;
  int n;
  // Rows: requests, software requests, level, vector
  logic [47:0] rows [12] = '{
    {30'h2000_0000, 7'h00, 3'h1, 8'h5d}, {30'h2000_0020, 7'h00, 3'h6, 8'h45},
    {30'h0000_0140, 7'h00, 3'h6, 8'h46}, {30'h0000_1200, 7'h00, 3'h5, 8'h49},
    {30'h0004_0000, 7'h04, 3'h3, 8'h52}, {30'h0000_0000, 7'h02, 3'h2, 8'h5f},
    {30'h0002_2000, 7'h00, 3'h4, 8'h4d}, {30'h0240_0000, 7'h00, 3'h2, 8'h56},
    {30'h0000_0000, 7'h3f, 3'h6, 8'h63}, {30'h0400_0000, 7'h01, 3'h1, 8'h5a},
    {30'h0060_0000, 7'h00, 3'h3, 8'h55}, {30'h0000_0000, 7'h00, 3'h0, 8'h00}};

  // ----------------------------------------------------------------
  // Design and core
  // ----------------------------------------------------------------
  fpic_ctrl u_fpic_ctrl
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .periph_req(periph_req),
    .sw_req(sw_req),
    .remap0_en(remap0_en),
    .remap0_src(remap0_src),
    .remap1_en(remap1_en),
    .remap1_src(remap1_src),
    .core_ack(core_ack),
    .irq_level_q(irq_level_q),
    .irq_vector_q(irq_vector_q),
    .ack_rd(ack_rd),
    .ack_addr(ack_addr),
    .ack_valid_q(ack_valid_q),
    .ack_data_q(ack_data_q),
    .wake(wake)
  );

  fpic_core_model u_fpic_core_model
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .irq_level(irq_level_q),
    .irq_vector(irq_vector_q),
    .mask(mask),
    .delay(delay),
    .core_ack(core_ack),
    .taken_vec(taken_vec)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("Counts: compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic drive(input logic [29:0] req, input logic [7:1] sw);
    @(posedge ref_clk);
    periph_req <= req;
    sw_req <= sw;
  endtask

  // Registered outputs follow one edge after the inputs are taken
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  task automatic rd(input logic [23:0] a);
    @(posedge ref_clk);
    ack_rd <= 1'b1;
    ack_addr <= a;
    @(posedge ref_clk);
    ack_rd <= 1'b0;
    #1;
    hit = ack_valid_q;
    v = ack_data_q;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    periph_req = '0;
    sw_req = '0;
    remap0_en = 1'b0;
    remap0_src = 5'h00;
    remap1_en = 1'b0;
    remap1_src = 5'h00;
    ack_rd = 1'b0;
    ack_addr = 24'h00_0000;
    mask = 3'h0;
    delay = 4'h0;
    repeat (10) @(posedge ref_clk);
    #1;
    chk(8'(irq_level_q), 8'h00);
    chk(irq_vector_q, 8'h00);
    chk(ack_data_q, 8'h00);
    chk(8'(ack_valid_q), 8'h00);
    chk(8'(wake), 8'h00);
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    $display("Test reset: done");
    // Level 7 pulse under a full mask, prompt and slow core
    for (int j = 0; j < 2; j++)
    begin
      drive(30'h1 << (j * 4), '0);
      mask <= 3'h7;
      delay <= 4'(j * 6);
      drive('0, '0);
      settle();
      chk(8'(irq_level_q), 8'h07);
      chk(irq_vector_q, 8'(64 + j * 4));
      chk(8'(wake), 8'h01);
      n = 0;
      while (irq_level_q !== 3'h0 && n < 30)
      begin
        settle();
        n++;
      end
      if (n == 30)
      begin
        err_total++;
        final_report();
      end
      chk(taken_vec, 8'(64 + j * 4));
      chk(8'(taken_vec >= 8'h40 && taken_vec < 8'h67), 8'h01);
    end
    $display("Test level 7 edge: done");
    for (int i = 0; i < 12; i++)
    begin
      drive(rows[i][47:18], rows[i][17:11]);
      settle();
      chk(8'(rows[i][10:8]), 8'(irq_level_q));
      chk(irq_vector_q, rows[i][7:0]);
      chk(8'(wake), 8'(|rows[i][47:11]));
      rd(i[0] ? 24'hff_ffff : 24'hff_ffc0);
      chk(8'(hit), 8'h01);
      chk(v, rows[i][10:8] == 3'h0 ? 8'h18 : rows[i][7:0]);
      settle();
      chk(8'(ack_valid_q), 8'h00);
    end
    // Full mask held every lower level off during the rows
    chk(taken_vec, 8'h44);
    $display("Test table rows: done");
    rd(24'hff_ffbf);
    chk(8'(hit), 8'h00);
    settle();
    chk(8'(ack_valid_q), 8'h00);
    $display("Test out of window: done");
    drive(30'h2000_0020, '0);
    remap0_en <= 1'b1;
    remap0_src <= 5'd29;
    settle();
    chk(8'(irq_level_q), 8'h06);
    chk(irq_vector_q, 8'h5d);
    drive(30'h3000_0020, '0);
    remap1_en <= 1'b1;
    remap1_src <= 5'd28;
    settle();
    chk(irq_vector_q, 8'h5d);
    drive(30'h3000_0020, '0);
    remap0_en <= 1'b0;
    settle();
    chk(irq_vector_q, 8'h5c);
    $display("Test remap: done");
    // Open mask: level 6 is taken, then a level 7 edge preempts it
    @(posedge ref_clk);
    mask <= 3'h0;
    repeat (10) @(posedge ref_clk);
    #1;
    chk(taken_vec, 8'h5c);
    drive(30'h3000_0020, 7'h40);
    repeat (13) @(posedge ref_clk);
    #1;
    chk(taken_vec, 8'h64);
    repeat (8) @(posedge ref_clk);
    #1;
    chk(taken_vec, 8'h5c);
    $display("Test mask and nesting: done");
    final_report();
  end
endmodule
